// File: testbench/jesd_deframer_link_sync_tb_top.sv
// bench: bring-up, prbs, resync, mismatch and calibrated link through the register port
`timescale 1ns/1ps
module jesd_deframer_link_sync_tb_top
  import jesd_link_pkg::*;
  ;
  logic sys_clk_in;
  logic rst_in;
  logic [4:0] avs_address_in;
  logic avs_read_in;
  logic avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic irq_out;
  logic tx_framer_en_out;
  logic mode_c;
  logic [1:0] prbs_sel;
  logic [1:0] tx_state;
  logic [31:0] q;
  int errors;
  int cmp_count;
  jesd_link_if jesd_link_if_inst ();
  jesd_deframer_sync #(.TRACK_CYCLES(40'h32)) jesd_deframer_sync_inst (
    .sys_clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
    .avs_waitrequest_out, .irq_out, .tx_framer_en_out, .link(jesd_link_if_inst.deframer));
  // framer follows the enable bit, so it cannot start before software turns it on
  jesd_framer_tx jesd_framer_tx_inst (
    .sys_clk_in, .rst_in, .enable_in(tx_framer_en_out), .mode_c_in(mode_c), .prbs_sel_in(prbs_sel),
    .link_m_in(4'h2), .link_l_in(4'h2), .sysref_en_in(1'b1), .tx_data_in(32'h0), .tx_ready_out(),
    .state_out(tx_state), .link(jesd_link_if_inst.framer));
  jesd_link_chk jesd_link_chk_inst (
    .sys_clk_in, .rst_in, .lane_data(jesd_link_if_inst.lane_data), .lane_k(jesd_link_if_inst.lane_k),
    .sync_n(jesd_link_if_inst.sync_n), .sysref(jesd_link_if_inst.sysref));
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // waitrequest and readdata are read at the rising edge, before that edge's updates land
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (avs_waitrequest_out !== 1'b0 && n < 40);
    q = avs_readdata_out;
    if (avs_waitrequest_out !== 1'b0)
      errors++;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : xfer
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] mask, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q & mask, exp);
  endtask : rd_chk
  task automatic cnt_chk(input logic [31:0] cfg, input logic nz);
    for (int l = 0; l < 4; l++)
    begin
      xfer(1'b1, REG_PRBS_CFG, cfg | 32'(l << 4));
      xfer(1'b0, REG_PRBS_CNT, 32'h0);
      chk({31'h0, q != 32'h0}, {31'h0, nz});
    end
  endtask : cnt_chk
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq_out !== 1'b1 && n < 3000)
    begin
      @(posedge sys_clk_in);
      n++;
    end
    chk({31'h0, irq_out}, 32'h1);
  endtask : wait_irq
  initial
  begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    errors++;
    end_of_test();
  end
  initial
  begin
    rst_in = 1'b1;
    avs_address_in = 5'h00;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0;
    mode_c = 1'b0;
    prbs_sel = PRBS_OFF;
    errors = 0;
    cmp_count = 0;
    q = 32'h0;
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rd_chk(REG_STATUS, 32'hF, 32'h8);
    rd_chk(REG_LINK_CFG, 32'hFFFFFFFF, 32'h22);
    rd_chk(REG_PRBS_CLR, 32'hFFFFFFFF, 32'h0);
    $display("reset values done");
    // framer still off: no commas arrive, so the request must persist
    xfer(1'b1, REG_CTRL, 32'h01);
    repeat (300) @(posedge sys_clk_in);
    rd_chk(REG_STATUS, 32'hF, 32'h1);
    rd_chk(REG_IRQ_ST, 32'h8, 32'h0);
    $display("comma search done");
    xfer(1'b1, REG_IRQ_MASK, 32'h01);
    xfer(1'b1, REG_CTRL, 32'h15);
    wait_irq();
    rd_chk(REG_STATUS, 32'hFF0F, 32'h220B);
    chk({30'h0, tx_state}, 32'h3);
    rd_chk(REG_IRQ_ST, 32'h9, 32'h9);
    xfer(1'b1, REG_IRQ_ST, 32'h1F);
    rd_chk(REG_IRQ_ST, 32'h1, 32'h0);
    chk({31'h0, irq_out}, 32'h0);
    $display("bring-up done");
    for (int p = 1; p < 4; p++)
    begin
      prbs_sel <= p[1:0];
      xfer(1'b1, REG_PRBS_CFG, 32'(p));
      repeat (20) @(posedge sys_clk_in);
      xfer(1'b1, REG_PRBS_CLR, 32'h1);
      repeat (50) @(posedge sys_clk_in);
      cnt_chk(32'(p), 1'b0);
    end
    prbs_sel <= PRBS_7;
    xfer(1'b1, REG_PRBS_CFG, 32'h2);
    repeat (50) @(posedge sys_clk_in);
    cnt_chk(32'h2, 1'b1);
    xfer(1'b1, REG_PRBS_CFG, 32'h6);
    xfer(1'b1, REG_PRBS_CLR, 32'h1);
    repeat (50) @(posedge sys_clk_in);
    cnt_chk(32'h6, 1'b1);
    xfer(1'b1, REG_PRBS_CFG, 32'h0);
    xfer(1'b1, REG_PRBS_CLR, 32'h1);
    cnt_chk(32'h0, 1'b0);
    $display("prbs done");
    prbs_sel <= PRBS_OFF;
    xfer(1'b1, REG_IRQ_ST, 32'h1F);
    xfer(1'b1, REG_CTRL, 32'h35);
    wait_irq();
    rd_chk(REG_IRQ_ST, 32'h3, 32'h3);
    rd_chk(REG_CTRL, 32'hFFFFFFFF, 32'h15);
    $display("resync done");
    xfer(1'b1, REG_LINK_CFG, 32'h21);
    xfer(1'b1, REG_IRQ_ST, 32'h1F);
    xfer(1'b1, REG_CTRL, 32'h35);
    repeat (400) @(posedge sys_clk_in);
    rd_chk(REG_IRQ_ST, 32'h3, 32'h2);
    xfer(1'b1, REG_LINK_CFG, 32'h22);
    wait_irq();
    $display("mismatch done");
    xfer(1'b1, REG_CTRL, 32'h00);
    mode_c <= 1'b1;
    xfer(1'b1, REG_IRQ_ST, 32'h1F);
    xfer(1'b1, REG_IRQ_MASK, 32'h10);
    xfer(1'b1, REG_CTRL, 32'h1B);
    rd_chk(REG_STATUS, 32'hF, 32'hC);
    wait_irq();
    rd_chk(REG_STATUS, 32'hF, 32'hD);
    rd_chk(REG_IRQ_ST, 32'h11, 32'h11);
    $display("calibrated link done");
    end_of_test();
  end
endmodule : jesd_deframer_link_sync_tb_top

// File: testbench/jesd_link_chk.sv
// checker for the framer-deframer link wires
`timescale 1ns/1ps
module jesd_link_chk
  import jesd_link_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // link wires
  input wire logic [31:0] lane_data,
  input wire logic [3:0] lane_k,
  input wire logic sync_n,
  input wire logic sysref
);
  logic comma_all;
  logic mark;
  logic [7:0] hi_cnt_r;
  logic [7:0] hi_cnt_nxt;
  assign comma_all = (lane_k == 4'hF) && (lane_data == {4{K28_5}});
  assign mark = (lane_k == 4'hF) && (lane_data == {4{K28_0}});
  // saturates so a long data phase never looks like a fresh release;
  // starts saturated so the first request after held is not taken for a failed alignment
  always_comb
  begin
    hi_cnt_nxt = hi_cnt_r;
    if (!sync_n)
      hi_cnt_nxt = 8'h00;
    else if (hi_cnt_r != 8'hFF)
      hi_cnt_nxt = hi_cnt_r + 8'h01;
  end
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      hi_cnt_r <= 8'hFF;
    else
      hi_cnt_r <= hi_cnt_nxt;
  end
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_comma_run;
    (!sync_n && comma_all) [*4];
  endsequence
  sequence s_ilas_start;
    comma_all ##1 mark;
  endsequence
  property p_comma_release;
    s_comma_run |=> sync_n;
  endproperty
  property p_rise_needs_commas;
    $rose(sync_n) |-> $past(comma_all) && $past(comma_all, 4);
  endproperty
  // the framer gets a few cycles to notice a new request
  property p_cgs_commas;
    (!sync_n) [*4] ##0 (|lane_k) |-> comma_all;
  endproperty
  property p_ilas_start;
    $rose(sync_n) |-> ##[1:3] mark;
  endproperty
  property p_ilas_mf;
    s_ilas_start |-> ##32 mark;
  endproperty
  property p_ilas_params;
    s_ilas_start |-> ##33 (lane_k == 4'h0 && lane_data == {4{lane_data[7:0]}});
  endproperty
  property p_fail_resync;
    $fell(sync_n) |-> hi_cnt_r > 8'h80 || hi_cnt_r inside {[8'h1E:8'h2D]};
  endproperty
  property p_lanes_paired;
    (|lane_k) |-> lane_k == 4'hF && lane_data == {4{lane_data[7:0]}};
  endproperty
  a_comma_release: assert property (p_comma_release) else $error("sync held after commas");
  a_rise_needs_commas: assert property (p_rise_needs_commas) else $error("sync rose early");
  a_cgs_commas: assert property (p_cgs_commas) else $error("no commas in search");
  a_ilas_start: assert property (p_ilas_start) else $error("no alignment start");
  a_ilas_mf: assert property (p_ilas_mf) else $error("multiframe marker missing");
  a_ilas_params: assert property (p_ilas_params) else $error("bad parameter char");
  a_fail_resync: assert property (p_fail_resync) else $error("late alignment fallback");
  a_lanes_paired: assert property (p_lanes_paired) else $error("lanes differ");
endmodule : jesd_link_chk

// File: verilog/jesd_deframer_sync.sv
// receive-side link bring-up, prbs checker and register slave
// Summary of operation
// - held until init, then request sync, or calibrate instead when CTRL_MODE_C is set
// - framer sends commas while sync requested
// - four commas release sync, enter alignment
// - no comma run keeps sync low forever
// - second multiframe parameters must match config
// - alignment lasts about four multiframes
// - failed alignment re-requests sync within five multiframes
// - data fault restarts through sync and alignment
// - 204C calibrates up, tracking refresh every 60s
// - own transmit framer enabled by CTRL_TX_EN alone; CTRL_INIT does not wait for it
// - prbs sequence and check location selectable
// - per-lane error counts, one lane read
// - sysref gated until configured
// - link state readable
// - converter and lane counts identical both ends
// - lane mode per lane, sample mode lane0
// - polynomial off, 7, 15 or 31
// - one clear resets all lane counters
`timescale 1ns/1ps
module jesd_deframer_sync
  import jesd_link_pkg::*;
#(
  parameter logic [39:0] TRACK_CYCLES = TRACK_CYCLES_DEF
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // avalon-mm slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // system
  output logic irq_out,
  output logic tx_framer_en_out,
  // link
  jesd_link_if.deframer link
);
  logic [4:0] ctrl_r, ctrl_nxt;
  logic [5:0] pcfg_r, pcfg_nxt;
  logic [7:0] lcfg_r, lcfg_nxt;
  logic [4:0] irq_st_r, irq_st_nxt;
  logic [4:0] irq_mask_r, irq_mask_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_take, clr_pulse, resync_pulse;
  logic [4:0] events;

  link_state_t state_r, state_nxt;
  logic sync_n_r, sync_n_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [7:0] tmo_r, tmo_nxt;
  logic [7:0] rxp_r, rxp_nxt;
  logic [39:0] trk_r, trk_nxt;
  logic ev_up, ev_lost, ev_trk;

  logic sref_m_r, sref_s_r, sref_d_r;
  logic [NUM_LANES-1:0] comma_hit, err_hit;
  logic [31:0] err_cnt [NUM_LANES];
  prbs_poly_t poly;
  logic in_data;

  assign poly = prbs_poly_t'(pcfg_r[1:0]);
  assign in_data = (state_r == ST_DATA) || (state_r == ST_CLINK);

  // bus: one wait cycle, then the answer stands at the edge where waitrequest is low
  always_comb
  begin
    ack_nxt = (avs_read_in || avs_write_in) && !ack_r;
    avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_r;
    wr_take = avs_write_in && ack_r;
    clr_pulse = wr_take && (avs_address_in == REG_PRBS_CLR) && avs_writedata_in[0];
    resync_pulse = wr_take && (avs_address_in == REG_CTRL) && avs_writedata_in[CTRL_RESYNC];
    ctrl_nxt = ctrl_r;
    pcfg_nxt = pcfg_r;
    lcfg_nxt = lcfg_r;
    irq_mask_nxt = irq_mask_r;
    irq_st_nxt = irq_st_r;
    rdata_nxt = rdata_r;
    if (wr_take)
    begin
      case (avs_address_in)
        REG_CTRL: ctrl_nxt = avs_writedata_in[4:0];
        REG_PRBS_CFG: pcfg_nxt = avs_writedata_in[5:0];
        REG_LINK_CFG: lcfg_nxt = avs_writedata_in[7:0];
        REG_IRQ_MASK: irq_mask_nxt = avs_writedata_in[4:0];
        REG_IRQ_ST: irq_st_nxt = irq_st_r & ~avs_writedata_in[4:0];
        default: ;
      endcase
    end
    // set wins over a clear in the same cycle
    irq_st_nxt = irq_st_nxt | events;
    if (avs_read_in && !ack_r)
    begin
      case (avs_address_in)
        REG_CTRL: rdata_nxt = {27'h0000000, ctrl_r};
        REG_PRBS_CFG: rdata_nxt = {26'h0000000, pcfg_r};
        REG_PRBS_CNT: rdata_nxt = pcfg_r[PCFG_LOC] ? err_cnt[0] : err_cnt[pcfg_r[5:4]];
        REG_STATUS: rdata_nxt = {16'h0000, rxp_r, 4'h0, sync_n_r, state_r};
        REG_IRQ_ST: rdata_nxt = {27'h0000000, irq_st_r};
        REG_IRQ_MASK: rdata_nxt = {27'h0000000, irq_mask_r};
        REG_LINK_CFG: rdata_nxt = {24'h000000, lcfg_r};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl_r <= CTRL_RESET;
      pcfg_r <= PCFG_RESET;
      lcfg_r <= LINK_CFG_RESET;
      irq_st_r <= 5'h00;
      irq_mask_r <= IRQ_MASK_RESET;
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      pcfg_r <= pcfg_nxt;
      lcfg_r <= lcfg_nxt;
      irq_st_r <= irq_st_nxt;
      irq_mask_r <= irq_mask_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_readdata_out = rdata_r;
  assign irq_out = |(irq_st_r & irq_mask_r);
  assign tx_framer_en_out = ctrl_r[CTRL_TX_EN];

  // sysref pin: two flops, then edge detect on the second
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sref_m_r <= 1'b0;
      sref_s_r <= 1'b0;
      sref_d_r <= 1'b0;
    end
    else
    begin
      sref_m_r <= link.sysref;
      sref_s_r <= sref_m_r;
      sref_d_r <= sref_s_r;
    end
  end

  assign events[IRQ_UP] = ev_up;
  assign events[IRQ_LOST] = ev_lost;
  assign events[IRQ_PRBS] = |err_hit;
  assign events[IRQ_SYSREF] = ctrl_r[CTRL_SYSREF_EN] && sref_s_r && !sref_d_r;
  assign events[IRQ_TRACK] = ev_trk;

  // per-lane comma detect and self-synchronising prbs check
  generate
    for (genvar i = 0; i < NUM_LANES; i++)
    begin : g_lane
      logic [30:0] hist_r, hist_nxt;
      logic [31:0] cnt_lane_r, cnt_lane_nxt;
      logic [3:0] errs;
      logic active;
      assign comma_hit[i] = link.lane_k[i] && (link.lane_data[8*i +: 8] == K28_5);
      always_comb
      begin
        hist_nxt = hist_r;
        errs = 4'h0;
        for (int b = 0; b < 8; b++)
        begin
          if (prbs_pred(hist_nxt, poly) != link.lane_data[8*i + b])
            errs = errs + 4'h1;
          hist_nxt = {hist_nxt[29:0], link.lane_data[8*i + b]};
        end
        active = (poly != PRBS_OFF) && (!pcfg_r[PCFG_LOC] || (i == 0 && in_data));
        err_hit[i] = active && (errs != 4'h0);
        cnt_lane_nxt = cnt_lane_r;
        if (clr_pulse)
          cnt_lane_nxt = 32'h00000000;
        else if (err_hit[i] && (cnt_lane_r <= 32'hFFFFFFF0))
          cnt_lane_nxt = cnt_lane_r + {28'h0000000, errs};
      end
      always_ff @(posedge sys_clk_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          hist_r <= PRBS_SEED;
          cnt_lane_r <= 32'h00000000;
        end
        else
        begin
          hist_r <= hist_nxt;
          cnt_lane_r <= cnt_lane_nxt;
        end
      end
      assign err_cnt[i] = cnt_lane_r;
    end
  endgenerate

  // link bring-up state machine
  always_comb
  begin
    state_nxt = state_r;
    sync_n_nxt = sync_n_r;
    cnt_nxt = cnt_r;
    tmo_nxt = tmo_r;
    rxp_nxt = rxp_r;
    trk_nxt = trk_r;
    ev_up = 1'b0;
    ev_lost = 1'b0;
    ev_trk = 1'b0;
    case (state_r)
      ST_HELD:
      begin
        sync_n_nxt = 1'b1;
        cnt_nxt = 16'h0000;
        if (ctrl_r[CTRL_INIT])
        begin
          state_nxt = ctrl_r[CTRL_MODE_C] ? ST_CAL : ST_CGS;
          sync_n_nxt = ctrl_r[CTRL_MODE_C];
        end
      end
      ST_CGS:
      begin
        sync_n_nxt = 1'b0;
        cnt_nxt = (&comma_hit) ? cnt_r + 16'h0001 : 16'h0000;
        if ((&comma_hit) && (cnt_r == {8'h00, CGS_RUN - 8'h01}))
        begin
          state_nxt = ST_ILAS;
          sync_n_nxt = 1'b1;
          cnt_nxt = 16'h0000;
          tmo_nxt = 8'h00;
        end
      end
      ST_ILAS:
      begin
        tmo_nxt = tmo_r + 8'h01;
        if (cnt_r == 16'h0000)
          cnt_nxt = (link.lane_k[0] && link.lane_data[7:0] == K28_0) ? 16'h0001 : 16'h0000;
        else
          cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r == {8'h00, MF_CHARS + 8'h01})
          rxp_nxt = link.lane_data[7:0];
        if ((cnt_r == {8'h00, MF_CHARS + 8'h01}) && (link.lane_data[7:0] != lcfg_r))
        begin
          state_nxt = ST_CGS;
          sync_n_nxt = 1'b0;
          ev_lost = 1'b1;
        end
        else if (tmo_r == ILAS_TIMEOUT - 8'h01)
        begin
          state_nxt = ST_CGS;
          sync_n_nxt = 1'b0;
          ev_lost = 1'b1;
        end
        else if (cnt_r == {8'h00, ILAS_LEN - 8'h01})
        begin
          state_nxt = ST_DATA;
          ev_up = 1'b1;
        end
      end
      ST_DATA:
      begin
        sync_n_nxt = 1'b1;
        // a control character or a forced resync drops back to comma search
        if ((|link.lane_k) || resync_pulse)
        begin
          state_nxt = ST_CGS;
          sync_n_nxt = 1'b0;
          cnt_nxt = 16'h0000;
          ev_lost = 1'b1;
        end
      end
      ST_CAL:
      begin
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r == CAL_CYCLES - 16'h0001)
        begin
          state_nxt = ST_CLINK;
          rxp_nxt = lcfg_r;
          trk_nxt = 40'h0000000000;
          ev_up = 1'b1;
        end
      end
      ST_CLINK:
      begin
        if (ctrl_r[CTRL_TRACK_EN])
        begin
          trk_nxt = trk_r + 40'h0000000001;
          if (trk_r >= TRACK_CYCLES - 40'h0000000001)
          begin
            trk_nxt = 40'h0000000000;
            rxp_nxt = lcfg_r;
            ev_trk = 1'b1;
          end
        end
      end
      default:
      begin
        state_nxt = ST_HELD;
        sync_n_nxt = 1'b1;
      end
    endcase
    if (!ctrl_r[CTRL_INIT])
    begin
      state_nxt = ST_HELD;
      sync_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_r <= ST_HELD;
      sync_n_r <= 1'b1;
      cnt_r <= 16'h0000;
      tmo_r <= 8'h00;
      rxp_r <= 8'h00;
      trk_r <= 40'h0000000000;
    end
    else
    begin
      state_r <= state_nxt;
      sync_n_r <= sync_n_nxt;
      cnt_r <= cnt_nxt;
      tmo_r <= tmo_nxt;
      rxp_r <= rxp_nxt;
      trk_r <= trk_nxt;
    end
  end

  assign link.sync_n = sync_n_r;
endmodule : jesd_deframer_sync

// File: verilog/jesd_framer_tx.sv
// transmit framer end: commas, lane alignment, data or prbs
`timescale 1ns/1ps
module jesd_framer_tx
  import jesd_link_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // control
  input wire logic enable_in,
  input wire logic mode_c_in,
  input wire logic [1:0] prbs_sel_in,
  input wire logic [3:0] link_m_in,
  input wire logic [3:0] link_l_in,
  input wire logic sysref_en_in,
  // user data
  input wire logic [31:0] tx_data_in,
  output logic tx_ready_out,
  output logic [1:0] state_out,
  // link
  jesd_link_if.framer link
);
  tx_state_t state_r, state_nxt;
  logic [7:0] idx_r, idx_nxt;
  logic [4:0] mf_r, mf_nxt;
  logic sync_d_r;
  logic [30:0] gen_r, gen_nxt;
  logic [7:0] gen_byte;
  logic [31:0] data_r, data_nxt;
  logic [3:0] k_r, k_nxt;
  logic sysref_r, sysref_nxt;
  prbs_poly_t poly;

  assign poly = prbs_poly_t'(prbs_sel_in);

  always_comb
  begin
    gen_nxt = gen_r;
    gen_byte = 8'h00;
    for (int b = 0; b < 8; b++)
    begin
      gen_byte[b] = prbs_pred(gen_nxt, poly);
      gen_nxt = {gen_nxt[29:0], gen_byte[b]};
    end
    if (state_r != TX_DATA || poly == PRBS_OFF)
      gen_nxt = gen_r;
    state_nxt = state_r;
    idx_nxt = idx_r;
    data_nxt = 32'h00000000;
    k_nxt = 4'h0;
    mf_nxt = mf_r + 5'h01;
    sysref_nxt = sysref_en_in && (mf_r == 5'h00);
    case (state_r)
      TX_IDLE:
        if (enable_in)
          state_nxt = mode_c_in ? TX_DATA : TX_CGS;
      TX_CGS:
      begin
        data_nxt = {4{K28_5}};
        k_nxt = 4'hF;
        idx_nxt = 8'h00;
        if (link.sync_n && !sync_d_r)
          state_nxt = TX_ILAS;
      end
      TX_ILAS:
      begin
        idx_nxt = idx_r + 8'h01;
        if (idx_r[4:0] == 5'h00)
        begin
          data_nxt = {4{K28_0}};
          k_nxt = 4'hF;
        end
        else if (idx_r == MF_CHARS + 8'h01)
          data_nxt = {4{link_m_in, link_l_in}};
        else
          data_nxt = {4{idx_r}};
        if (!link.sync_n)
          state_nxt = TX_CGS;
        else if (idx_r == ILAS_LEN - 8'h01)
          state_nxt = TX_DATA;
      end
      TX_DATA:
      begin
        data_nxt = (poly == PRBS_OFF) ? tx_data_in : {4{gen_byte}};
        if (!mode_c_in && !link.sync_n)
          state_nxt = TX_CGS;
      end
      default: state_nxt = TX_IDLE;
    endcase
    if (!enable_in)
      state_nxt = TX_IDLE;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_r <= TX_IDLE;
      idx_r <= 8'h00;
      mf_r <= 5'h00;
      sync_d_r <= 1'b0;
      gen_r <= PRBS_SEED;
      data_r <= 32'h00000000;
      k_r <= 4'h0;
      sysref_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      mf_r <= mf_nxt;
      sync_d_r <= link.sync_n;
      gen_r <= gen_nxt;
      data_r <= data_nxt;
      k_r <= k_nxt;
      sysref_r <= sysref_nxt;
    end
  end

  assign link.lane_data = data_r;
  assign link.lane_k = k_r;
  assign link.sysref = sysref_r;
  assign tx_ready_out = (state_r == TX_DATA) && (poly == PRBS_OFF);
  assign state_out = state_r;
endmodule : jesd_framer_tx

// File: verilog/jesd_link_if.sv
// lane, sync and sysref wires between framer and deframer
`timescale 1ns/1ps
interface jesd_link_if;
  logic [31:0] lane_data;
  logic [3:0] lane_k;
  logic sync_n;
  logic sysref;
  modport deframer (input lane_data, input lane_k, input sysref, output sync_n);
  modport framer (output lane_data, output lane_k, output sysref, input sync_n);
endinterface : jesd_link_if

// File: verilog/jesd_link_pkg.sv
// shared constants, types and helpers for the jesd link bring-up pair
package jesd_link_pkg;
  localparam int NUM_LANES = 4;
  localparam logic [7:0] K28_5 = 8'hBC;
  localparam logic [7:0] K28_0 = 8'h1C;
  localparam logic [7:0] MF_CHARS = 8'h20;
  localparam logic [7:0] CGS_RUN = 8'h04;
  localparam logic [7:0] ILAS_LEN = 8'h80;
  localparam logic [7:0] ILAS_TIMEOUT = 8'hA0;
  localparam logic [15:0] CAL_CYCLES = 16'h0100;
  localparam longint TRACK_PERIOD_S = 60;
  localparam longint CLK_HZ = 250000000;
  localparam logic [39:0] TRACK_CYCLES_DEF = 40'(TRACK_PERIOD_S * CLK_HZ);
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_PRBS_CFG = 5'h04;
  localparam logic [4:0] REG_PRBS_CLR = 5'h08;
  localparam logic [4:0] REG_PRBS_CNT = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_IRQ_ST = 5'h14;
  localparam logic [4:0] REG_IRQ_MASK = 5'h18;
  localparam logic [4:0] REG_LINK_CFG = 5'h1C;
  localparam int CTRL_INIT = 0;
  localparam int CTRL_MODE_C = 1;
  localparam int CTRL_SYSREF_EN = 2;
  localparam int CTRL_TRACK_EN = 3;
  localparam int CTRL_TX_EN = 4;
  localparam int CTRL_RESYNC = 5;
  localparam int PCFG_LOC = 2;
  localparam int IRQ_UP = 0;
  localparam int IRQ_LOST = 1;
  localparam int IRQ_PRBS = 2;
  localparam int IRQ_SYSREF = 3;
  localparam int IRQ_TRACK = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [5:0] PCFG_RESET = 6'h00;
  localparam logic [7:0] LINK_CFG_RESET = 8'h22;
  localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
  localparam logic [30:0] PRBS_SEED = 31'h7FFFFFFF;

  typedef enum logic [1:0] {
    PRBS_OFF = 2'b00,
    PRBS_7 = 2'b01,
    PRBS_15 = 2'b10,
    PRBS_31 = 2'b11
  } prbs_poly_t;

  typedef enum logic [2:0] {
    ST_HELD = 3'b000,
    ST_CGS = 3'b001,
    ST_ILAS = 3'b010,
    ST_DATA = 3'b011,
    ST_CAL = 3'b100,
    ST_CLINK = 3'b101
  } link_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_CGS = 2'b01,
    TX_ILAS = 2'b10,
    TX_DATA = 2'b11
  } tx_state_t;

  // next bit of the selected sequence, h[0] being the newest bit
  function automatic logic prbs_pred(input logic [30:0] h, input prbs_poly_t poly);
    case (poly)
      PRBS_7: prbs_pred = h[6] ^ h[5];
      PRBS_15: prbs_pred = h[14] ^ h[13];
      PRBS_31: prbs_pred = h[30] ^ h[27];
      default: prbs_pred = 1'b0;
    endcase
  endfunction : prbs_pred
endpackage : jesd_link_pkg
